// >>> dv/branch_skip_bit_instr_unit_tb.sv
// Purpose: self-checking bench for bsbiu_core
// Assumes: one op in flight, inputs moved on falling edges
// Notes: bench tracks pc in pcx and flags in fx
`timescale 1ns/1ps
module branch_skip_bit_instr_unit_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    bsbiu_pkg::bsbiu_instr_s ins = '0;
    logic vld = 1'b0;
    logic [15:0] pz = 16'h0000;
    logic fwe = 1'b0;
    logic [7:0] fwd = 8'h00;
    logic rdy;
    logic ret;
    logic [15:0] pc;
    logic [7:0] fl;
    logic [7:0] iod;
    bsbiu_pkg::bsbiu_reg_wr_s rw, grw;
    bsbiu_pkg::bsbiu_io_wr_s iw, giw;
    bsbiu_pkg::bsbiu_push_s ps, gps;
    logic [15:0] pcx = 16'h0000;
    logic [7:0] fx = 8'h00;
    int err_total = 0;
    int check_count = 0;
    int bb [10] = '{3, 1, 0, 0, 2, 2, 5, 6, 3, 7};

    bsbiu_core uut (.clk(clk), .rst(rst), .instr(ins), .instr_valid(vld),
        .pointer_z(pz), .io_rdata(iod), .flags_we(fwe), .flags_wdata(fwd),
        .ready(rdy), .retire(ret), .pc(pc), .flags(fl), .reg_wr(rw),
        .io_wr(iw), .push(ps));
    bsbiu_io_model io (.clk(clk), .raddr(ins.io_addr), .wr(iw), .rdata(iod));

    initial begin
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        chk16({8'h00, g}, {8'h00, e});
    endtask

    // flags load only when nothing is accepted, so valid stays low here
    task automatic setf(input logic [7:0] f);
        fwe = 1'b1;
        fwd = f;
        @(negedge clk);
        fwe = 1'b0;
        fx = f;
    endtask

    function automatic logic [15:0] rel(input logic [11:0] k, input logic br);
        logic [15:0] s;
        s = br ? {{9{k[6]}}, k[6:0]} : {{4{k[11]}}, k};
        return pcx + 16'h0001 + s;
    endfunction

    function automatic logic [15:0] nx(input int w);
        return pcx + 16'(w);
    endfunction

    // issue one op, check retire and pc, then count cycles until ready
    task automatic exe(input bsbiu_pkg::bsbiu_op_e op, input logic [11:0] k,
            input logic [15:0] epc, input int cost);
        int n;
        ins.op = op;
        ins.offset = k;
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        grw = rw;
        giw = iw;
        gps = ps;
        chk8({7'h00, ret}, 8'h01);
        chk16(pc, epc);
        pcx = epc;
        n = 1;
        while (rdy !== 1'b1 && n < 6) begin
            @(negedge clk);
            n++;
        end
        if (n == 6) begin
            err_total++;
            print_verdict();
        end
        chk8(8'(n), 8'(cost));
        // one idle edge: valid never falls and rises in one step
        @(negedge clk);
    endtask

    task automatic cmp(input bsbiu_pkg::bsbiu_op_e op, input logic [7:0] a,
            input logic [7:0] b, input logic [7:0] f);
        logic ci;
        logic h;
        logic v;
        logic c;
        logic z;
        logic [7:0] r;
        setf(f);
        ins.rd_val = a;
        ins.rr_val = b;
        ci = (op == bsbiu_pkg::op_compare_with_carry) & f[0];
        r = a - b - 8'(ci);
        h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        z = (r == 8'h00) & (op != bsbiu_pkg::op_compare_with_carry | f[1]);
        exe(op, 12'h000, pcx + 16'h0001, 1);
        chk8(fl, {f[7:6], h, r[7] ^ v, v, r[7], z, c});
        chk8({7'h00, grw.we}, 8'h00);
    endtask

    task automatic alu(input bsbiu_pkg::bsbiu_op_e op, input logic [7:0] a,
            input logic [7:0] f, input logic [7:0] d, input logic [7:0] ef);
        setf(f);
        ins.rd_val = a;
        ins.rd_addr = 5'h11;
        exe(op, 12'h000, pcx + 16'h0001, 1);
        chk16({grw.we, 2'h0, grw.addr, grw.data}, {3'h4, 5'h11, d});
        chk8(fl, ef);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] m;
        logic [7:0] f;
        logic tk;
        int i;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        for (int j = 0; j < 40; j++) begin
            i = j / 2;
            m = 8'h01 << bb[i / 2];
            f = (j % 2 == 1) ? (~m & 8'hF7) : m;
            ins.bit_sel = 3'(bb[i / 2]);
            setf(f);
            tk = (f[bb[i / 2]] ^ ((i inside {10, 11}) & f[3]));
            tk = tk == ((i % 2 == 0) ^ (i inside {6, 7, 10, 11}));
            exe(bsbiu_pkg::bsbiu_op_e'(bsbiu_pkg::op_branch_flag_set + i),
                12'h07E, tk ? rel(12'h07E, 1'b1) : pcx + 16'h0001,
                tk ? 2 : 1);
            chk8(fl, fx);
        end
        setf(8'hA5);
        exe(bsbiu_pkg::op_relative_jump, 12'h7FF, rel(12'h7FF, 1'b0),
            2);
        exe(bsbiu_pkg::op_relative_jump, 12'hFFF, rel(12'hFFF, 1'b0),
            2);
        pz = 16'h1234;
        exe(bsbiu_pkg::op_pointer_jump, 12'h000, 16'h1234, 2);
        m = 8'h00;
        exe(bsbiu_pkg::op_relative_call, 12'h800, rel(12'h800, 1'b0),
            3);
        chk16({gps.we, gps.addr[14:0]}, {1'b1, 15'h1235});
        pz = 16'h0F00;
        exe(bsbiu_pkg::op_pointer_call, 12'h000, 16'h0F00, 3);
        chk16({gps.we, gps.addr[14:0]}, {1'b1, 15'h0A36});
        chk8(fl, 8'hA5);
        ins.rd_val = 8'h3C;
        ins.rr_val = 8'h3C;
        ins.next_two_word = 1'b1;
        exe(bsbiu_pkg::op_compare_skip_equal, 12'h000, nx(3), 3);
        ins.next_two_word = 1'b0;
        exe(bsbiu_pkg::op_compare_skip_equal, 12'h000, nx(2), 2);
        ins.rr_val = 8'h3D;
        exe(bsbiu_pkg::op_compare_skip_equal, 12'h000, nx(1), 1);
        ins.bit_sel = 3'h2;
        exe(bsbiu_pkg::op_skip_reg_bit_set, 12'h000, nx(2), 2);
        exe(bsbiu_pkg::op_skip_reg_bit_clear, 12'h000, nx(1), 1);
        ins.io_addr = 5'h1F;
        ins.bit_sel = 3'h0;
        exe(bsbiu_pkg::op_io_bit_set, 12'h000, nx(1), 2);
        chk16({2'h0, giw.we, giw.addr, giw.data}, 16'h3FBB);
        exe(bsbiu_pkg::op_skip_io_bit_set, 12'h000, nx(2), 2);
        ins.bit_sel = 3'h7;
        exe(bsbiu_pkg::op_io_bit_clear, 12'h000, nx(1), 2);
        chk16({giw.data, giw.mask}, 16'h3B80);
        ins.next_two_word = 1'b1;
        exe(bsbiu_pkg::op_skip_io_bit_clear, 12'h000, nx(3), 3);
        exe(bsbiu_pkg::op_skip_io_bit_set, 12'h000, nx(1), 1);
        chk8(fl, 8'hA5);
        cmp(bsbiu_pkg::op_register_compare, 8'h10, 8'h20, 8'h00);
        cmp(bsbiu_pkg::op_compare_with_carry, 8'h05, 8'h04, 8'h01);
        cmp(bsbiu_pkg::op_compare_with_carry, 8'h05, 8'h04, 8'h03);
        cmp(bsbiu_pkg::op_compare_immediate, 8'h80, 8'h01, 8'hC0);
        alu(bsbiu_pkg::op_shift_left_logical, 8'hC5, 8'h20, 8'h8A,
            8'h35);
        alu(bsbiu_pkg::op_shift_left_logical, 8'h00, 8'hFF, 8'h00,
            8'hE2);
        alu(bsbiu_pkg::op_shift_right_logical, 8'h81, 8'h20, 8'h40,
            8'h39);
        alu(bsbiu_pkg::op_register_clear, 8'h9C, 8'h3F, 8'h00,
            8'h23);
        alu(bsbiu_pkg::op_register_set_ones, 8'h00, 8'h5A, 8'hFF,
            8'h5A);
        print_verdict();
    end
endmodule

// >>> dv/bsbiu_io_model.sv
// Purpose: io register space facing the unit
// Assumes: writes land on the edge after the unit strobes them
// Notes: preset pattern, not reset, so bit tests see known data
`timescale 1ns/1ps
module bsbiu_io_model (
    input wire logic clk,
    input wire logic [4:0] raddr,
    input wire bsbiu_pkg::bsbiu_io_wr_s wr,
    output logic [7:0] rdata
);
    logic [7:0] mem [32];
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end
    assign rdata = mem[raddr];
    always @(posedge clk) begin
        if (wr.we) begin
            mem[wr.addr] <= wr.data;
        end
    end
endmodule

// >>> hdl/bsbiu_core.sv
// Purpose: executes jumps, calls, compares, skips, branches, bit ops
// Assumes: operands and io read data valid with instr_valid
// Notes: all effects land at the accept edge; ready then stalls for multi-cycle ops only
//
// How it works
// RULE1: jumps load pc, two cycles, flags kept
// RULE2: calls push return, load pc, three cycles
// RULE3: equal registers skip next instruction
// RULE4: compares set flags, result discarded
// RULE5: register bit clear/set skips next
// RULE6: io bit clear/set skips next
// RULE7: flag-select branch on set or clear
// RULE8: equal branches test zero flag
// RULE9: carry branches test carry flag
// RULE10: minus/plus branches test negative flag
// RULE11: signed branches test negative xor overflow
// RULE12: half-carry branches test half-carry
// RULE13: transfer-bit branches test transfer flag
// RULE14: overflow branches test overflow flag
// RULE15: interrupt branches test interrupt enable
// RULE16: io bit set/clear, two cycles
// RULE17: left shift, zero in, flags updated
// RULE18: right shift, zero in, flags updated
// RULE19: clear via xor; set writes all ones
// RULE20: offsets signed, from next instruction
// RULE21: skip costs one, two or three cycles
`timescale 1ns/1ps
module bsbiu_core (
    input wire logic clk,
    input wire logic rst,
    input wire bsbiu_pkg::bsbiu_instr_s instr,
    input wire logic instr_valid,
    input wire logic [15:0] pointer_z,
    input wire logic [7:0] io_rdata,
    input wire logic flags_we,
    input wire logic [7:0] flags_wdata,
    output logic ready,
    output logic retire,
    output logic [15:0] pc,
    output logic [7:0] flags,
    output bsbiu_pkg::bsbiu_reg_wr_s reg_wr,
    output bsbiu_pkg::bsbiu_io_wr_s io_wr,
    output bsbiu_pkg::bsbiu_push_s push
);
    logic acc;
    logic [15:0] pc_plus1;
    logic [15:0] jmp_target;
    logic [15:0] br_target;
    logic [15:0] skip_len;
    logic [1:0] skip_cyc;
    logic is_branch;
    logic br_cond;
    logic cmp_h, cmp_s, cmp_v, cmp_n, cmp_z, cmp_c;
    logic cmp_cin;
    logic cmp_chain;
    logic [7:0] shl_val;
    logic [7:0] shr_val;
    logic [7:0] bit_mask;
    logic [15:0] next_pc;
    logic [7:0] next_flags;
    logic [1:0] next_cyc;
    logic next_rd_we;
    logic [7:0] next_rd_data;
    logic next_io_we;
    logic [7:0] next_io_data;
    logic next_push_we;
    logic [1:0] cnt;

    assign acc = instr_valid & ready;
    assign pc_plus1 = pc + bsbiu_pkg::PC_STEP;
    // offsets count words past the following instruction [RULE20]
    assign jmp_target = pc_plus1 + {{4{instr.offset[11]}}, instr.offset};
    assign br_target = pc_plus1 + {{9{instr.offset[6]}}, instr.offset[6:0]};
    // a skipped double-word instruction costs one cycle more [RULE21]
    assign skip_len = instr.next_two_word ? bsbiu_pkg::PC_SKIP_TWO
                                          : bsbiu_pkg::PC_SKIP_ONE;
    assign skip_cyc = instr.next_two_word ? bsbiu_pkg::CYC_SKIP_TWO
                                          : bsbiu_pkg::CYC_SKIP_ONE;
    assign shl_val = {instr.rd_val[6:0], 1'b0};
    assign shr_val = {1'b0, instr.rd_val[7:1]};
    assign bit_mask = 8'h01 << instr.bit_sel;
    assign cmp_chain = (instr.op == bsbiu_pkg::op_compare_with_carry);
    assign cmp_cin = cmp_chain & flags[bsbiu_pkg::FLAG_C];

    bsbiu_sub_flags u_cmp (
        .a(instr.rd_val),
        .b(instr.rr_val),
        .cin(cmp_cin),
        .z_chain(cmp_chain),
        .z_old(flags[bsbiu_pkg::FLAG_Z]),
        .h(cmp_h),
        .s(cmp_s),
        .v(cmp_v),
        .n(cmp_n),
        .z(cmp_z),
        .c(cmp_c)
    );

    ////////////////////////////////////////////////////////////////////
    // branch condition select
    always_comb begin
        is_branch = 1'b1;
        br_cond = 1'b0;
        unique case (instr.op)
            bsbiu_pkg::op_branch_flag_set:
                br_cond = flags[instr.bit_sel]; // [RULE7]
            bsbiu_pkg::op_branch_flag_clear:
                br_cond = ~flags[instr.bit_sel]; // [RULE7]
            bsbiu_pkg::op_branch_equal:
                br_cond = flags[bsbiu_pkg::FLAG_Z]; // [RULE8]
            bsbiu_pkg::op_branch_not_equal:
                br_cond = ~flags[bsbiu_pkg::FLAG_Z]; // [RULE8]
            bsbiu_pkg::op_branch_carry_set, bsbiu_pkg::op_branch_lower:
                br_cond = flags[bsbiu_pkg::FLAG_C]; // [RULE9]
            bsbiu_pkg::op_branch_carry_clear,
            bsbiu_pkg::op_branch_same_higher:
                br_cond = ~flags[bsbiu_pkg::FLAG_C]; // [RULE9]
            bsbiu_pkg::op_branch_minus:
                br_cond = flags[bsbiu_pkg::FLAG_N]; // [RULE10]
            bsbiu_pkg::op_branch_plus:
                br_cond = ~flags[bsbiu_pkg::FLAG_N]; // [RULE10]
            // computed from n and v, not the stored sign flag
            bsbiu_pkg::op_branch_signed_ge:
                br_cond = ~(flags[bsbiu_pkg::FLAG_N]
                          ^ flags[bsbiu_pkg::FLAG_V]); // [RULE11]
            bsbiu_pkg::op_branch_signed_lt:
                br_cond = flags[bsbiu_pkg::FLAG_N]
                        ^ flags[bsbiu_pkg::FLAG_V]; // [RULE11]
            bsbiu_pkg::op_branch_halfcarry_set:
                br_cond = flags[bsbiu_pkg::FLAG_H]; // [RULE12]
            bsbiu_pkg::op_branch_halfcarry_clear:
                br_cond = ~flags[bsbiu_pkg::FLAG_H]; // [RULE12]
            bsbiu_pkg::op_branch_xferbit_set:
                br_cond = flags[bsbiu_pkg::FLAG_T]; // [RULE13]
            bsbiu_pkg::op_branch_xferbit_clear:
                br_cond = ~flags[bsbiu_pkg::FLAG_T]; // [RULE13]
            bsbiu_pkg::op_branch_overflow_set:
                br_cond = flags[bsbiu_pkg::FLAG_V]; // [RULE14]
            bsbiu_pkg::op_branch_overflow_clear:
                br_cond = ~flags[bsbiu_pkg::FLAG_V]; // [RULE14]
            bsbiu_pkg::op_branch_irq_enabled:
                br_cond = flags[bsbiu_pkg::FLAG_I]; // [RULE15]
            bsbiu_pkg::op_branch_irq_disabled:
                br_cond = ~flags[bsbiu_pkg::FLAG_I]; // [RULE15]
            default:
                is_branch = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // execute: next pc, flags, writes and cycle cost
    always_comb begin
        next_pc = pc_plus1;
        next_flags = flags;
        next_cyc = bsbiu_pkg::CYC_ONE;
        next_rd_we = 1'b0;
        next_rd_data = instr.rd_val;
        next_io_we = 1'b0;
        next_io_data = io_rdata;
        next_push_we = 1'b0;
        unique case (instr.op)
            bsbiu_pkg::op_relative_jump: begin
                next_pc = jmp_target; // [RULE1]
                next_cyc = bsbiu_pkg::CYC_JUMP;
            end
            bsbiu_pkg::op_pointer_jump: begin
                next_pc = pointer_z; // [RULE1]
                next_cyc = bsbiu_pkg::CYC_JUMP;
            end
            bsbiu_pkg::op_relative_call: begin
                next_pc = jmp_target; // [RULE2]
                next_cyc = bsbiu_pkg::CYC_CALL;
                next_push_we = 1'b1;
            end
            bsbiu_pkg::op_pointer_call: begin
                next_pc = pointer_z; // [RULE2]
                next_cyc = bsbiu_pkg::CYC_CALL;
                next_push_we = 1'b1;
            end
            bsbiu_pkg::op_compare_skip_equal: begin
                if (instr.rd_val == instr.rr_val) begin
                    next_pc = pc + skip_len; // [RULE3]
                    next_cyc = skip_cyc;
                end
            end
            bsbiu_pkg::op_register_compare,
            bsbiu_pkg::op_compare_with_carry,
            bsbiu_pkg::op_compare_immediate: begin
                next_flags[bsbiu_pkg::FLAG_H] = cmp_h; // [RULE4]
                next_flags[bsbiu_pkg::FLAG_S] = cmp_s;
                next_flags[bsbiu_pkg::FLAG_V] = cmp_v;
                next_flags[bsbiu_pkg::FLAG_N] = cmp_n;
                next_flags[bsbiu_pkg::FLAG_Z] = cmp_z;
                next_flags[bsbiu_pkg::FLAG_C] = cmp_c;
            end
            bsbiu_pkg::op_skip_reg_bit_clear: begin
                if (!instr.rd_val[instr.bit_sel]) begin
                    next_pc = pc + skip_len; // [RULE5]
                    next_cyc = skip_cyc;
                end
            end
            bsbiu_pkg::op_skip_reg_bit_set: begin
                if (instr.rd_val[instr.bit_sel]) begin
                    next_pc = pc + skip_len; // [RULE5]
                    next_cyc = skip_cyc;
                end
            end
            bsbiu_pkg::op_skip_io_bit_clear: begin
                if (!io_rdata[instr.bit_sel]) begin
                    next_pc = pc + skip_len; // [RULE6]
                    next_cyc = skip_cyc;
                end
            end
            bsbiu_pkg::op_skip_io_bit_set: begin
                if (io_rdata[instr.bit_sel]) begin
                    next_pc = pc + skip_len; // [RULE6]
                    next_cyc = skip_cyc;
                end
            end
            // the whole read byte is written back with only the addressed bit
            // changed, so write-one-to-clear neighbours reading 1 get a 1 written
            bsbiu_pkg::op_io_bit_set: begin
                next_io_we = 1'b1;
                next_io_data = io_rdata | bit_mask; // [RULE16]
                next_cyc = bsbiu_pkg::CYC_IO_BIT;
            end
            bsbiu_pkg::op_io_bit_clear: begin
                next_io_we = 1'b1;
                next_io_data = io_rdata & ~bit_mask; // [RULE16]
                next_cyc = bsbiu_pkg::CYC_IO_BIT;
            end
            bsbiu_pkg::op_shift_left_logical: begin
                next_rd_we = 1'b1;
                next_rd_data = shl_val; // [RULE17]
                next_flags[bsbiu_pkg::FLAG_C] = instr.rd_val[7];
                next_flags[bsbiu_pkg::FLAG_N] = shl_val[7];
                next_flags[bsbiu_pkg::FLAG_Z] = (shl_val == 8'h00);
                next_flags[bsbiu_pkg::FLAG_V] = shl_val[7] ^ instr.rd_val[7];
                next_flags[bsbiu_pkg::FLAG_S] = instr.rd_val[7];
            end
            bsbiu_pkg::op_shift_right_logical: begin
                next_rd_we = 1'b1;
                next_rd_data = shr_val; // [RULE18]
                next_flags[bsbiu_pkg::FLAG_C] = instr.rd_val[0];
                next_flags[bsbiu_pkg::FLAG_N] = 1'b0;
                next_flags[bsbiu_pkg::FLAG_Z] = (shr_val == 8'h00);
                next_flags[bsbiu_pkg::FLAG_V] = instr.rd_val[0];
                next_flags[bsbiu_pkg::FLAG_S] = instr.rd_val[0];
            end
            bsbiu_pkg::op_register_clear: begin
                next_rd_we = 1'b1;
                next_rd_data = instr.rd_val ^ instr.rd_val; // [RULE19]
                next_flags[bsbiu_pkg::FLAG_Z] = 1'b1;
                next_flags[bsbiu_pkg::FLAG_N] = 1'b0;
                next_flags[bsbiu_pkg::FLAG_V] = 1'b0;
                next_flags[bsbiu_pkg::FLAG_S] = 1'b0;
            end
            bsbiu_pkg::op_register_set_ones: begin
                next_rd_we = 1'b1;
                next_rd_data = bsbiu_pkg::ONES_VAL; // [RULE19]
            end
            default: begin
                if (is_branch && br_cond) begin
                    next_pc = br_target; // [RULE20]
                    next_cyc = bsbiu_pkg::CYC_TAKEN;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // program counter and flags; accept beats an outside flag write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc <= bsbiu_pkg::PC_RST;
        end else if (acc) begin
            pc <= next_pc;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags <= bsbiu_pkg::FLAGS_RST;
        end else if (acc) begin
            flags <= next_flags;
        end else if (flags_we) begin
            flags <= flags_wdata;
        end
    end

    // stall for the remaining cycles of a multi-cycle instruction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
            ready <= 1'b1;
        end else if (acc) begin
            cnt <= next_cyc - bsbiu_pkg::CYC_ONE;
            ready <= (next_cyc == bsbiu_pkg::CYC_ONE);
        end else if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
            ready <= (cnt == 2'h1);
        end
    end

    // write strobes are one-cycle pulses at the accept edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            retire <= 1'b0;
            reg_wr <= '0;
            io_wr <= '0;
            push <= '0;
        end else begin
            retire <= acc;
            reg_wr.we <= acc & next_rd_we;
            reg_wr.addr <= instr.rd_addr;
            reg_wr.data <= next_rd_data;
            io_wr.we <= acc & next_io_we;
            io_wr.addr <= instr.io_addr;
            io_wr.data <= next_io_data;
            io_wr.mask <= bit_mask;
            push.we <= acc & next_push_we; // [RULE2]
            push.addr <= pc_plus1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    jump_timing_a: assert property ( // [RULE1]
        acc && instr.op == bsbiu_pkg::op_relative_jump
        |=> !ready ##1 ready)
        else $error("jump did not take two cycles");
    pointer_jump_a: assert property ( // [RULE1]
        acc && instr.op == bsbiu_pkg::op_pointer_jump
        |=> pc == $past(pointer_z) && flags == $past(flags))
        else $error("pointer jump target or flags wrong");
    call_push_a: assert property ( // [RULE2]
        acc && instr.op == bsbiu_pkg::op_relative_call
        |=> push.we && push.addr == $past(pc) + 16'h0001
            ##1 !ready ##1 ready)
        else $error("call push or timing wrong");
    skip_equal_a: assert property ( // [RULE3]
        acc && instr.op == bsbiu_pkg::op_compare_skip_equal
        && instr.rd_val == instr.rr_val && instr.next_two_word
        |=> pc == $past(pc) + 16'h0003 ##1 !ready ##1 ready)
        else $error("skip over double word wrong");
    compare_nowr_a: assert property ( // [RULE4]
        acc && instr.op == bsbiu_pkg::op_register_compare
        |=> !reg_wr.we && ready)
        else $error("compare wrote a register");
    no_skip_a: assert property ( // [RULE5]
        acc && instr.op == bsbiu_pkg::op_skip_reg_bit_set
        && !instr.rd_val[instr.bit_sel]
        |=> pc == $past(pc) + 16'h0001 && ready)
        else $error("false skip advanced too far");
    branch_untaken_a: assert property ( // [RULE8]
        acc && instr.op == bsbiu_pkg::op_branch_equal
        && !flags[bsbiu_pkg::FLAG_Z]
        |=> ready && pc == $past(pc) + 16'h0001)
        else $error("untaken branch wrong");
    signed_taken_a: assert property ( // [RULE11]
        acc && instr.op == bsbiu_pkg::op_branch_signed_lt
        && (flags[bsbiu_pkg::FLAG_N] ^ flags[bsbiu_pkg::FLAG_V])
        |=> !ready ##1 ready)
        else $error("taken signed branch timing wrong");
    io_bit_a: assert property ( // [RULE16]
        acc && instr.op == bsbiu_pkg::op_io_bit_set
        |=> io_wr.we && (io_wr.data & io_wr.mask) == io_wr.mask
            ##1 !io_wr.we && ready)
        else $error("io bit set wrong");
    shift_left_a: assert property ( // [RULE17]
        acc && instr.op == bsbiu_pkg::op_shift_left_logical
        |=> reg_wr.we && reg_wr.data[0] == 1'b0
            && flags[bsbiu_pkg::FLAG_C] == $past(instr.rd_val[7]))
        else $error("left shift wrong");
    clear_reg_a: assert property ( // [RULE19]
        acc && instr.op == bsbiu_pkg::op_register_clear
        |=> reg_wr.data == 8'h00 && flags[bsbiu_pkg::FLAG_Z])
        else $error("register clear wrong");

    cover_call_c: cover property (
        acc && instr.op == bsbiu_pkg::op_pointer_call);
    cover_skip_c: cover property (
        acc && instr.op == bsbiu_pkg::op_skip_io_bit_clear
        && !io_rdata[instr.bit_sel]);
    cover_branch_c: cover property (
        acc && is_branch && br_cond ##2 acc);
endmodule

// >>> hdl/bsbiu_pkg.sv
// Purpose: shared constants and types for the branch, skip and bit unit
// Assumes: one core clock, flags packed I T H S V N Z C from bit 7 down
// Notes: operations arrive pre-decoded as bsbiu_op_e
package bsbiu_pkg;

    localparam int PC_W = 16;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
    localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] ONES_VAL = 8'hFF;
    localparam logic [7:0] ZERO_VAL = 8'h00;

    // status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // offset field: jumps and calls use 12 bits, branches the low 7
    localparam int JMP_OFF_W = 12;
    localparam int BR_OFF_W = 7;

    // cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_JUMP = 2'h2;
    localparam logic [1:0] CYC_CALL = 2'h3;
    localparam logic [1:0] CYC_TAKEN = 2'h2;
    localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
    localparam logic [1:0] CYC_IO_BIT = 2'h2;

    typedef enum logic [5:0] {
        op_nop,
        op_relative_jump, op_pointer_jump,
        op_relative_call, op_pointer_call,
        op_compare_skip_equal,
        op_register_compare, op_compare_with_carry, op_compare_immediate,
        op_skip_reg_bit_clear, op_skip_reg_bit_set,
        op_skip_io_bit_clear, op_skip_io_bit_set,
        op_branch_flag_set, op_branch_flag_clear,
        op_branch_equal, op_branch_not_equal,
        op_branch_carry_set, op_branch_carry_clear,
        op_branch_same_higher, op_branch_lower,
        op_branch_minus, op_branch_plus,
        op_branch_signed_ge, op_branch_signed_lt,
        op_branch_halfcarry_set, op_branch_halfcarry_clear,
        op_branch_xferbit_set, op_branch_xferbit_clear,
        op_branch_overflow_set, op_branch_overflow_clear,
        op_branch_irq_enabled, op_branch_irq_disabled,
        op_io_bit_set, op_io_bit_clear,
        op_shift_left_logical, op_shift_right_logical,
        op_register_clear, op_register_set_ones
    } bsbiu_op_e;

    typedef struct packed {
        bsbiu_op_e op;
        logic [4:0] rd_addr;
        logic [7:0] rd_val;
        logic [7:0] rr_val;
        logic [2:0] bit_sel;
        logic [4:0] io_addr;
        logic [11:0] offset;
        logic next_two_word;
    } bsbiu_instr_s;

    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } bsbiu_reg_wr_s;

    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
        logic [7:0] mask;
    } bsbiu_io_wr_s;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
    } bsbiu_push_s;

endpackage

// >>> hdl/bsbiu_sub_flags.sv
// Purpose: flags of a subtraction whose result is thrown away
// Assumes: cin already gated by the caller
// Notes: z_chain keeps zero sticky across a carry chain
`timescale 1ns/1ps
module bsbiu_sub_flags (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire logic z_chain,
    input wire logic z_old,
    output logic h,
    output logic s,
    output logic v,
    output logic n,
    output logic z,
    output logic c
);
    logic [7:0] r;

    always_comb begin
        r = a - b - {7'h00, cin};
        h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        n = r[7];
        c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        z = (r == 8'h00) & (z_chain ? z_old : 1'b1);
        s = n ^ v;
    end
endmodule
